// ==== inc/dnsc_pkg.sv ====
// shared constants and types for the dial number store control
package dnsc_pkg;
    // four-bit digit codes
    localparam logic [3:0] DIG_STAR = 4'ha;
    localparam logic [3:0] DIG_HASH = 4'hb;
    localparam logic [3:0] DIG_A = 4'hc;
    localparam logic [3:0] DIG_B = 4'hd;
    localparam logic [3:0] DIG_C = 4'he;
    localparam logic [3:0] DIG_D = 4'hf;
    localparam logic [3:0] DIG_PAUSE = 4'h0;
    // keys: 0..15 are digit codes carried unchanged into key space
    localparam logic [4:0] KEY_PROG = 5'h10;
    localparam logic [4:0] KEY_REDIAL = 5'h11;
    localparam logic [4:0] KEY_PAUSE = 5'h12;
    localparam logic [4:0] KEY_MEM0 = 5'h14;
    localparam int STORE_DEPTH = 18;
    localparam int FIFO_DEPTH = 10;
    localparam int REP_ON_CHIP = 10;
    localparam int EXT_MEM_MAX = 5;
    localparam int EXT_BLOCK = 20;
    // display prefix codes
    localparam logic [2:0] PFX_NONE = 3'h0;
    localparam logic [2:0] PFX_REDIAL = 3'h1;
    localparam logic [2:0] PFX_XREDIAL = 3'h2;
    localparam logic [2:0] PFX_EMERG = 3'h3;
    localparam logic [2:0] PFX_REP = 3'h4;
    localparam logic [2:0] PFX_NOTE = 3'h5;
    localparam logic [2:0] PFX_ERROR = 3'h7;
    // apb register map
    localparam logic [11:0] ADR_CTRL = 12'h000;
    localparam logic [11:0] ADR_STAT = 12'h004;
    localparam logic [11:0] ADR_EXTCNT = 12'h008;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_EKB_BIT = 1;
    localparam int CTRL_DIRECT_BIT = 2;
    typedef enum {
        DNSC_IDLE, DNSC_DIAL, DNSC_PHELD, DNSC_PADDR, DNSC_PPROG, DNSC_EMPROG,
        DNSC_PTAP, DNSC_NOTE, DNSC_REPGO, DNSC_CLEAR
    } dnsc_state_t;
endpackage

// ==== src/dnsc_top.sv ====
// keypad command interpreter for the dialer's number stores
`timescale 1ns/10ps
module dnsc_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic chipEnable,
    input wire logic keyValid,
    input wire logic [4:0] keyCode,
    input wire logic progKeyHeld,
    input wire logic clear2580Held,
    input wire logic txReady,
    output logic txValid,
    output logic [3:0] txDigit,
    output logic muteActive,
    output logic dispValid,
    output logic [2:0] dispPrefix,
    output logic [3:0] dispDigit,
    output logic [2:0] memory_select_pins,
    output logic [6:0] extAddr,
    output logic repValid,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import dnsc_pkg::*;

    // pin synchronisers (first stage read only by second)
    logic [3:0] syncA_r;
    logic [3:0] syncB_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            syncA_r <= 4'h0;
            syncB_r <= 4'h0;
        end else begin
            syncA_r <= {clear2580Held, progKeyHeld, keyValid, chipEnable};
            syncB_r <= syncA_r;
        end
    end
    wire ceS = syncB_r[0];
    wire keyS = syncB_r[1];
    wire progS = syncB_r[2];
    wire clrS = syncB_r[3];
    logic keyD_r;
    logic progD_r;
    logic ceD_r;
    logic [4:0] keyCodeA_r;
    logic [4:0] keyCodeS_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            keyD_r <= 1'b0;
            progD_r <= 1'b0;
            ceD_r <= 1'b0;
            keyCodeA_r <= 5'h00;
            keyCodeS_r <= 5'h00;
        end else begin
            keyD_r <= keyS;
            progD_r <= progS;
            ceD_r <= ceS;
            keyCodeA_r <= keyCode; // two stages like the valid bit, stable while pressed
            keyCodeS_r <= keyCodeA_r;
        end
    end
    wire keyPress = keyS & ~keyD_r;
    wire progRise = progS & ~progD_r;
    wire progFall = ~progS & progD_r;
    wire hookOff = ceS & ~ceD_r;
    wire hookOn = ~ceS & ceD_r;
    wire isDigit = ~keyCodeS_r[4];
    wire [3:0] kd = keyCodeS_r[3:0];
    wire isMem = (keyCodeS_r >= KEY_MEM0) & (keyCodeS_r < KEY_MEM0 + 5'd10);

    // apb control register
    logic [31:0] ctrl_r;
    logic [2:0] extCount_r;
    wire pdMode = ~ctrl_r[CTRL_PD_BIT];
    wire keypad_expansion_option = ctrl_r[CTRL_EKB_BIT];
    wire direct = ctrl_r[CTRL_DIRECT_BIT];
    wire apbWr = psel & penable & pwrite;
    wire apbRd = psel & penable & ~pwrite;
    wire adrOk = (paddr == ADR_CTRL) | (paddr == ADR_STAT) | (paddr == ADR_EXTCNT);

    // digit stores, all in one 4-bit format
    logic [3:0] redial_r [STORE_DEPTH];
    logic [3:0] xred_r [STORE_DEPTH];
    logic [3:0] emerg_r [STORE_DEPTH];
    logic [3:0] rep_r [REP_ON_CHIP][STORE_DEPTH];
    logic [4:0] redLen_r;
    logic [4:0] xredLen_r;
    logic [4:0] emLen_r;
    logic [4:0] repLen_r [REP_ON_CHIP];
    // send queue: index into active source plus overflow fifo
    logic [3:0] fifo_r [FIFO_DEPTH];
    logic [3:0] fHead_r;
    logic [3:0] fTail_r;
    logic [3:0] fCount_r;
    logic [4:0] srcLen_r;
    logic [4:0] srcPos_r;
    logic [1:0] srcSel_r;
    logic [3:0] srcRep_r;
    logic [4:0] callLen_r;
    logic lastWasProg_r;
    logic firstKey_r;
    dnsc_state_t state_r;
    logic [3:0] addr_r;
    logic [1:0] addrCnt_r;
    logic [4:0] progLen_r;

    function automatic logic [3:0] inc10(input logic [3:0] v);
        inc10 = (v == 4'(FIFO_DEPTH - 1)) ? 4'h0 : v + 4'h1;
    endfunction

    // current source digit
    wire [3:0] srcDigit = (srcSel_r == 2'd0) ? redial_r[srcPos_r] :
                          (srcSel_r == 2'd1) ? xred_r[srcPos_r] :
                          (srcSel_r == 2'd2) ? emerg_r[srcPos_r] :
                          rep_r[srcRep_r][srcPos_r];
    wire srcPend = srcPos_r < srcLen_r;
    wire [3:0] headDigit = srcPend ? srcDigit : fifo_r[fHead_r];
    wire anyPend = srcPend | (fCount_r != 4'h0);
    // pulse mode skips star, hash and A-D without sending
    wire skipDigit = pdMode & (headDigit > 4'h9);
    wire txFire = ceS & anyPend & (skipDigit | (txValid & txReady));
    assign txValid = ceS & anyPend & ~skipDigit;
    assign txDigit = headDigit;
    assign muteActive = ceS & anyPend;
    wire fifoFull = fCount_r == 4'(FIFO_DEPTH);
    // digit appended to the call: into redial store, when redial is the source, until 18, then fifo
    wire appendKey = (state_r == DNSC_DIAL) & keyPress & isDigit;

    // two-digit repertory address to memory select
    wire [6:0] twoDig = 7'(addr_r) * 7'd10 + 7'(kd);
    wire [6:0] repBase = keypad_expansion_option ? 7'd0 : 7'd10;
    wire [6:0] repOff = twoDig - repBase;
    wire [2:0] repBlk = (repOff >= 7'd80) ? 3'd4 : 3'(repOff / 7'(EXT_BLOCK));
    wire extHit = (addrCnt_r == 2'd1) & (twoDig >= repBase) & (repBlk < extCount_r);

    // main interpreter
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= DNSC_IDLE;
            redLen_r <= 5'h00;
            xredLen_r <= 5'h00;
            emLen_r <= 5'h00;
            for (int i = 0; i < REP_ON_CHIP; i++) begin
                repLen_r[i] <= 5'h00;
            end
            fHead_r <= 4'h0;
            fTail_r <= 4'h0;
            fCount_r <= 4'h0;
            srcLen_r <= 5'h00;
            srcPos_r <= 5'h00;
            srcSel_r <= 2'd0;
            srcRep_r <= 4'h0;
            callLen_r <= 5'h00;
            lastWasProg_r <= 1'b0;
            firstKey_r <= 1'b1;
            addr_r <= 4'h0;
            addrCnt_r <= 2'd0;
            progLen_r <= 5'h00;
            dispValid <= 1'b0;
            dispPrefix <= PFX_NONE;
            dispDigit <= 4'h0;
            memory_select_pins <= 3'h0;
            extAddr <= 7'h00;
            repValid <= 1'b0;
        end else begin
            dispValid <= 1'b0;
            repValid <= 1'b0;
            // drain path, one digit per accepted send or pulse-mode skip
            if (txFire && srcPend) begin
                srcPos_r <= srcPos_r + 5'h01;
            end else if (txFire) begin
                fHead_r <= inc10(fHead_r);
            end
            if (!ceS) begin
                // on-hook: idle, stores kept
                state_r <= DNSC_IDLE;
                srcLen_r <= 5'h00;
                srcPos_r <= 5'h00;
                fCount_r <= 4'h0;
                fHead_r <= 4'h0;
                fTail_r <= 4'h0;
                firstKey_r <= 1'b1;
                if (hookOn && lastWasProg_r && callLen_r != 5'h00) begin
                    xredLen_r <= callLen_r;
                    for (int i = 0; i < STORE_DEPTH; i++) begin
                        xred_r[i] <= redial_r[i];
                    end
                end
                if (clrS) begin
                    state_r <= DNSC_CLEAR;
                end
            end else begin
                if (keyPress) begin
                    lastWasProg_r <= 1'b0;
                    firstKey_r <= 1'b0;
                end
                if (progRise) begin
                    lastWasProg_r <= 1'b1;
                    firstKey_r <= 1'b0;
                end
                if (appendKey) begin
                    dispValid <= 1'b1;
                    dispDigit <= kd;
                    if (srcLen_r < 5'(STORE_DEPTH)) begin
                        // (extended copy is the source, saved copy untouched)
                        if (srcSel_r == 2'd0) begin
                            redial_r[srcLen_r] <= kd;
                            redLen_r <= srcLen_r + 5'h01;
                            callLen_r <= srcLen_r + 5'h01;
                        end
                        srcLen_r <= srcLen_r + 5'h01;
                    end else if (!fifoFull) begin
                        fifo_r[fTail_r] <= kd;
                        fTail_r <= inc10(fTail_r);
                    end // full fifo drops the digit
                end
                if (appendKey && srcLen_r >= 5'(STORE_DEPTH) && !fifoFull) begin
                    fCount_r <= fCount_r + 4'h1 - 4'(txFire & ~srcPend);
                end else if (txFire && !srcPend) begin
                    fCount_r <= fCount_r - 4'h1;
                end
                case (state_r)
                    DNSC_CLEAR: begin
                        if (!clrS) begin
                            redLen_r <= 5'h00;
                            xredLen_r <= 5'h00;
                            emLen_r <= 5'h00;
                            for (int i = 0; i < REP_ON_CHIP; i++) begin
                                repLen_r[i] <= 5'h00;
                            end
                            state_r <= DNSC_IDLE;
                        end
                    end
                    DNSC_IDLE: begin
                        if (keyPress && direct) begin
                            srcSel_r <= 2'd2;
                            srcLen_r <= emLen_r;
                            srcPos_r <= 5'h00;
                            dispPrefix <= PFX_EMERG;
                            dispValid <= 1'b1;
                            state_r <= DNSC_DIAL;
                        end else if (keyPress && isDigit && (!pdMode || kd <= 4'h9)) begin
                            redial_r[0] <= kd;
                            redLen_r <= 5'h01;
                            callLen_r <= 5'h01;
                            srcSel_r <= 2'd0;
                            srcLen_r <= 5'h01;
                            srcPos_r <= 5'h00;
                            dispPrefix <= PFX_NONE;
                            dispDigit <= kd;
                            dispValid <= 1'b1;
                            state_r <= DNSC_DIAL;
                        end else if (keyPress && keyCodeS_r == KEY_REDIAL) begin
                            srcSel_r <= 2'd0;
                            srcLen_r <= redLen_r;
                            srcPos_r <= 5'h00;
                            callLen_r <= redLen_r;
                            dispPrefix <= PFX_REDIAL;
                            dispValid <= 1'b1;
                            state_r <= DNSC_DIAL;
                        end else if (progRise) begin
                            // programming allowed only as first key
                            state_r <= firstKey_r ? DNSC_PHELD : DNSC_PTAP;
                            addrCnt_r <= 2'd0;
                            progLen_r <= 5'h00;
                        end else if (keyPress) begin
                            dispPrefix <= PFX_ERROR;
                            dispValid <= 1'b1;
                        end
                    end
                    DNSC_DIAL: begin
                        if (progRise) begin
                            state_r <= DNSC_PTAP; // chain via program key
                            addrCnt_r <= 2'd0;
                        end
                    end
                    DNSC_PHELD, DNSC_PADDR: begin
                        if (!direct && ctrl_r[CTRL_DIRECT_BIT] == 1'b0 && progS && keyPress && !isDigit) begin
                            dispPrefix <= PFX_ERROR;
                            dispValid <= 1'b1;
                        end else if (progS && keyPress && isDigit) begin
                            if (addrCnt_r == 2'd0 && extCount_r != 3'h0) begin
                                addr_r <= kd;
                                addrCnt_r <= 2'd1;
                                state_r <= DNSC_PADDR;
                            end else begin
                                // one digit on-chip address or two digit external
                                addr_r <= (addrCnt_r == 2'd0) ? kd : 4'(repOff % 7'(EXT_BLOCK) % 7'd10);
                                memory_select_pins <= repBlk;
                                extAddr <= twoDig;
                                repValid <= extHit;
                                state_r <= DNSC_PPROG;
                            end
                        end else if (progS && keyPress && isMem && keypad_expansion_option) begin
                            addr_r <= 4'(keyCodeS_r - KEY_MEM0);
                            state_r <= DNSC_PPROG;
                        end else if (direct && state_r == DNSC_PHELD) begin
                            state_r <= DNSC_EMPROG;
                            emLen_r <= 5'h00;
                        end else if (progFall) begin
                            state_r <= DNSC_PTAP;
                        end
                    end
                    DNSC_PPROG: begin
                        if (keyPress && isDigit && progLen_r < 5'(STORE_DEPTH)) begin
                            rep_r[addr_r][progLen_r] <= kd;
                            progLen_r <= progLen_r + 5'h01;
                            dispPrefix <= PFX_REP;
                            dispDigit <= kd;
                            dispValid <= 1'b1;
                        end
                        if (progFall) begin
                            repLen_r[addr_r] <= progLen_r;
                            state_r <= DNSC_IDLE;
                        end
                    end
                    DNSC_EMPROG: begin
                        if (keyPress && isDigit && emLen_r < 5'(STORE_DEPTH)) begin
                            emerg_r[emLen_r] <= kd;
                            emLen_r <= emLen_r + 5'h01;
                            dispPrefix <= PFX_EMERG;
                            dispDigit <= kd;
                            dispValid <= 1'b1;
                        end
                        if (progFall) begin
                            state_r <= DNSC_IDLE;
                        end
                    end
                    DNSC_PTAP: begin
                        if (keyPress && keyCodeS_r == KEY_REDIAL) begin
                            srcSel_r <= 2'd1;
                            srcLen_r <= xredLen_r;
                            srcPos_r <= 5'h00;
                            dispPrefix <= PFX_XREDIAL;
                            dispValid <= 1'b1;
                            state_r <= DNSC_DIAL;
                        end else if (progRise) begin
                            state_r <= DNSC_NOTE;
                            xredLen_r <= 5'h00;
                            progLen_r <= 5'h00;
                        end else if (keyPress && ((isMem && keypad_expansion_option) || isDigit)) begin
                            srcRep_r <= isDigit ? kd : 4'(keyCodeS_r - KEY_MEM0);
                            state_r <= DNSC_REPGO;
                        end
                    end
                    DNSC_REPGO: begin
                        srcSel_r <= 2'd3; // manual digits follow
                        srcLen_r <= repLen_r[srcRep_r];
                        srcPos_r <= 5'h00;
                        dispPrefix <= PFX_REP;
                        dispValid <= 1'b1;
                        state_r <= DNSC_DIAL;
                    end
                    DNSC_NOTE: begin
                        if (keyPress && isDigit && progLen_r < 5'(STORE_DEPTH)) begin
                            xred_r[progLen_r] <= kd; // no dialing
                            progLen_r <= progLen_r + 5'h01;
                            dispPrefix <= PFX_NOTE;
                            dispDigit <= kd;
                            dispValid <= 1'b1;
                        end
                        if (progRise) begin
                            xredLen_r <= progLen_r;
                            state_r <= DNSC_IDLE;
                        end
                    end
                    default: state_r <= DNSC_IDLE;
                endcase
            end
        end
    end

    // apb slave, zero wait states
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            extCount_r <= 3'h0;
        end else if (apbWr && paddr == ADR_CTRL) begin
            ctrl_r <= pwdata & 32'h0000_0007;
        end else if (apbWr && paddr == ADR_EXTCNT) begin
            extCount_r <= (pwdata[2:0] > 3'(EXT_MEM_MAX)) ? 3'(EXT_MEM_MAX) : pwdata[2:0];
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~adrOk;
    wire [31:0] statWord = {16'h0000, 3'h0, callLen_r, fCount_r, anyPend, 3'(state_r)};
    assign prdata = !apbRd ? 32'h0 :
                    (paddr == ADR_CTRL) ? ctrl_r :
                    (paddr == ADR_STAT) ? statWord :
                    (paddr == ADR_EXTCNT) ? {29'h0, extCount_r} : 32'h0;
endmodule

// ==== testbench/dnsc_bench.sv ====
// self-checking bench for the dialer store control
`timescale 1ns/10ps
module dnsc_bench;
    import dnsc_pkg::*;
    logic mclk = 1'b0, rstn = 1'b0, chipEnable = 1'b0, keyValid = 1'b0, stall = 1'b0;
    logic prompt = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, prog = 1'b0;
    logic txReady, txValid, muteActive, dispValid, repValid, pready, pslverr;
    logic [4:0] keyCode = 5'h00;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] txDigit, dispDigit;
    logic [2:0] dispPrefix, memory_select_pins;
    logic [6:0] extAddr;
    logic [7:0] seed = 8'h1d;
    logic [3:0] exp[$];
    int error_cnt = 0, tests_run = 0;
    always #12.5 mclk = ~mclk;
    dnsc_top i_dnsc_top (.mclk(mclk), .rstn(rstn), .chipEnable(chipEnable), .keyValid(keyValid),
        .keyCode(keyCode), .progKeyHeld(prog), .clear2580Held(1'b0), .txReady(txReady),
        .txValid(txValid), .txDigit(txDigit), .muteActive(muteActive), .dispValid(dispValid),
        .dispPrefix(dispPrefix), .dispDigit(dispDigit), .memory_select_pins(memory_select_pins),
        .extAddr(extAddr), .repValid(repValid), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dnsc_line_model i_line (.mclk(mclk), .rstn(rstn), .stall(stall), .prompt(prompt),
        .txReady(txReady));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one bus transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            chk("bus answer", 1'b0, 1'b1);
            print_verdict();
        end
    endtask
    // press held past the sync lag, then a gap before the next key
    task automatic key(input logic [4:0] k);
        @(posedge mclk);
        keyCode <= k;
        keyValid <= 1'b1;
        repeat (6) @(posedge mclk);
        keyValid <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic hook();
        @(posedge mclk);
        chipEnable <= 1'b0;
        repeat (12) @(posedge mclk);
        chipEnable <= 1'b1;
        repeat (12) @(posedge mclk);
    endtask
    task automatic drain();
        int n;
        for (n = 0; n < 20000 && exp.size() > 0; n++) @(posedge mclk);
        chk("digits left unsent", exp.size(), 0);
        if (exp.size() > 0) print_verdict();
    endtask
    // each digit the line takes is matched with the oldest note
    always @(posedge mclk) begin
        if (rstn && txValid === 1'b1 && txReady === 1'b1) begin
            chk("tx digit", txDigit, exp.size() > 0 ? exp.pop_front() : 4'hx);
        end
    end
    initial begin
        repeat (90000) @(posedge mclk);
        chk("run length", 1'b0, 1'b1);
        print_verdict();
    end
    initial begin
        int k;
        logic [3:0] d;
        logic [3:0] keep[$];
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        for (int m = 0; m < 2; m++) begin
            // tone pass sends every code from 1 up, pulse pass only decimals
            hook();
            apb(1'b1, ADR_CTRL, 32'(1 - m));
            apb(1'b0, ADR_CTRL, 32'h0);
            chk("ctrl readback", rd[2:0], 3'(1 - m));
            for (k = 1; k < 16; k++) begin
                if (m == 0 || k < 10) exp.push_back(k[3:0]);
                key(k[4:0]);
            end
            drain();
        end
        // stalled line: eighteen stored, ten queued, the rest dropped
        hook();
        apb(1'b1, ADR_CTRL, 32'h1);
        stall <= 1'b1;
        prompt <= 1'b0;
        for (k = 0; k < 30; k++) begin
            seed = lfsr(seed);
            d = 4'(seed % 8'd9) + 4'h1;
            if (k < 28) exp.push_back(d);
            if (k < 18) keep.push_back(d);
            key({1'b0, d});
        end
        apb(1'b0, ADR_STAT, 32'h0);
        chk("fifo count", rd[7:4], 4'ha);
        chk("call length", rd[12:8], 5'd18);
        stall <= 1'b0;
        drain();
        // redial recalls the first eighteen, an extra key goes on after
        hook();
        prompt <= 1'b1;
        foreach (keep[i]) exp.push_back(keep[i]);
        exp.push_back(4'h5);
        key(KEY_REDIAL);
        key(5'h05);
        drain();
        // program on-chip entry 3 as 4 5, then tap and address to dial it
        hook();
        prog <= 1'b1;
        repeat (6) @(posedge mclk);
        key(5'h03);
        key(5'h04);
        key(5'h05);
        prog <= 1'b0;
        repeat (6) @(posedge mclk);
        exp.push_back(4'h4);
        exp.push_back(4'h5);
        prog <= 1'b1;
        repeat (6) @(posedge mclk);
        prog <= 1'b0;
        key(5'h03);
        drain();
        print_verdict();
    end
endmodule
bind dnsc_top dnsc_monitor i_dnsc_monitor (.mclk(mclk), .rstn(rstn), .chipEnable(chipEnable),
    .txReady(txReady), .txValid(txValid), .txDigit(txDigit), .dispValid(dispValid),
    .repValid(repValid), .memory_select_pins(memory_select_pins), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// ==== testbench/dnsc_line_model.sv ====
// line transmitter stand-in: takes digits at a pace set by the bench
`timescale 1ns/10ps
module dnsc_line_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic prompt,
    output logic txReady
);
    logic [2:0] pace_r;
    // slow pace takes one digit in eight cycles, to let the store back up
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pace_r <= 3'h0;
        end else begin
            pace_r <= pace_r + 3'h1;
        end
    end
    assign txReady = !stall && (prompt || pace_r == 3'h0);
endmodule

// ==== testbench/dnsc_monitor.sv ====
// port-level checks for the dialer store control
`timescale 1ns/10ps
module dnsc_monitor
    import dnsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic chipEnable,
    input wire logic txReady,
    input wire logic txValid,
    input wire logic [3:0] txDigit,
    input wire logic dispValid,
    input wire logic repValid,
    input wire logic [2:0] memory_select_pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import dnsc_pkg::*;
    logic toneMode_r;
    // address decode shared by the bus checks
    wire mapped = paddr == ADR_CTRL || paddr == ADR_STAT || paddr == ADR_EXTCNT;
    wire statRead = !pwrite && paddr == ADR_STAT;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence sAccess;
        psel && penable;
    endsequence
    // six low samples clear the two-flop sync and the state update
    sequence sOnHook;
        !chipEnable [*6];
    endsequence
    // mode copy lets the pulse check know which digits may go out
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            toneMode_r <= CTRL_RST[CTRL_PD_BIT];
        end else if (psel && penable && pwrite && paddr == ADR_CTRL) begin
            toneMode_r <= pwdata[CTRL_PD_BIT];
        end
    end
    AST_TX_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txDigit))
        else $error("digit withdrawn before the line took it");
    AST_PREADY: assert property (sAccess |-> pready)
        else $error("bus access not answered at once");
    AST_UNMAPPED: assert property (sAccess |-> (mapped ? !pslverr : pslverr && (pwrite || prdata == 32'h0)))
        else $error("unmapped access not refused");
    AST_ONHOOK: assert property (sOnHook |-> !txValid)
        else $error("digit offered while on hook");
    AST_PULSE_DEC: assert property (txValid && !toneMode_r |-> txDigit < DIG_STAR)
        else $error("nondecimal digit offered in pulse mode");
    AST_FIFO_CAP: assert property (sAccess ##0 statRead |-> prdata[7:4] <= 4'ha)
        else $error("overflow queue count above ten");
    AST_DISP_PULSE: assert property (dispValid |=> !dispValid)
        else $error("display strobe longer than one cycle");
    AST_REP_PULSE: assert property (repValid |=> !repValid)
        else $error("repertory strobe longer than one cycle");
    AST_SEL_RANGE: assert property (repValid |-> memory_select_pins <= 3'h4)
        else $error("memory select beyond fifth memory");
endmodule
